//--- radio_regs_map.vh
// Constants for the wake, analog control and channel register bank.
// Assumes an SPI slave front end clocked by ref_clk via pin sampling.
`ifndef RADIO_REGS_MAP_VH
`define RADIO_REGS_MAP_VH
`define ADDR_SYN_A        6'h01
`define ADDR_SYN_N        6'h02
`define ADDR_WAKE_EN      6'h1c
`define ADDR_WAKE_STAT    6'h1d
`define ADDR_ANALOG_CTL   6'h20
`define ADDR_CHANNEL      6'h21
`define ADDR_AGC_CTL      6'h2e
`define ADDR_RSSI_CTL     6'h2f
`define ADDR_MID_0        6'h3c
`define ADDR_MID_3        6'h3f
`define RST_WAKE_EN       8'h00
`define RST_WAKE_STAT     8'h01
`define RST_ANALOG_CTL    8'h00
`define RST_CHANNEL       8'h00
`define RST_SYN_A         8'h00
`define RST_SYN_N         8'h00
`define RST_AGC           8'h00
`define MASK_WAKE_EN      8'h01
`define MASK_ANALOG_CTL   8'h67
`define BIT_WAKE          0
`define BIT_SOFT_RST      0
`define BIT_AMP_INV       1
`define BIT_AMP_OE        2
`define BIT_MID_EN        5
`define BIT_AGC_EN        6
`define BIT_AN_SEL        7
`define FREQ_BASE_MHZ     12'd2401
`define READY_CYCLES      4'h8
`define SPI_ADDR_LAST     4'h7
`define SPI_DATA_FIRST    4'h8
`define SPI_DATA_LAST     4'hf
`define MID_VALUE         32'h5a5a_0001
`endif

//--- pin_sync.v
// Two-stage synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to ref_clk.
`timescale 1ns/1ps
module pin_sync
#(
    parameter W = 1
)
(
    input  wire         ref_clk,
    input  wire         srst,
    input  wire [W-1:0] pin_in,
    output wire [W-1:0] pin_out
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end
        else
        begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end
    assign pin_out = sync_q;
endmodule // pin_sync

//--- spi_slave.v
// SPI mode 0 slave: first byte is write flag plus 6-bit address,
// second byte is data. Assumes sck, mosi, ss_n already synchronised.
`timescale 1ns/1ps
`include "radio_regs_map.vh"
module spi_slave
(
    input  wire       ref_clk,
    input  wire       srst,
    input  wire       sck,
    input  wire       mosi,
    input  wire       ss_n,
    input  wire [7:0] rd_data,
    output reg        miso_q,
    output reg        rd_stb_q,
    output reg        wr_stb_q,
    output reg  [5:0] addr_q,
    output reg  [7:0] wr_data_q
);
    reg       sck_q;
    reg [3:0] cnt_q;
    reg [7:0] sh_q;
    reg       wr_q;
    wire      rise = sck & ~sck_q;
    wire      fall = ~sck & sck_q;
    wire [7:0] sh_d = {sh_q[6:0], mosi};
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            sck_q     <= 1'b0;
            cnt_q     <= 4'h0;
            sh_q      <= 8'h00;
            wr_q      <= 1'b0;
            miso_q    <= 1'b0;
            rd_stb_q  <= 1'b0;
            wr_stb_q  <= 1'b0;
            addr_q    <= 6'h00;
            wr_data_q <= 8'h00;
        end
        else
        begin
            sck_q    <= sck;
            rd_stb_q <= 1'b0;
            wr_stb_q <= 1'b0;
            // Load read data once the new address has settled
            if (rd_stb_q)
                sh_q <= rd_data;
            if (ss_n)
            begin
                cnt_q  <= 4'h0;
                miso_q <= 1'b0;
            end
            else if (rise)
            begin
                sh_q  <= sh_d;
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == `SPI_ADDR_LAST)
                begin
                    wr_q   <= sh_d[7];
                    addr_q <= sh_d[5:0];
                    if (!sh_d[7])
                        rd_stb_q <= 1'b1;
                end
                else if (cnt_q == `SPI_DATA_LAST)
                begin
                    if (wr_q)
                    begin
                        wr_stb_q  <= 1'b1;
                        wr_data_q <= sh_d;
                    end
                end
            end
            else if (fall && cnt_q >= `SPI_DATA_FIRST)
                miso_q <= sh_q[7];
        end
    end
endmodule // spi_slave

//--- radio_wake_analog_channel_regs.v
// Wake, analog control and channel register bank behind SPI.
// Assumes ref_clk at 125 MHz; all pins are asynchronous.
`timescale 1ns/1ps
`include "radio_regs_map.vh"
module radio_wake_analog_channel_regs
(
    input  wire        ref_clk,
    input  wire        srst,
    input  wire        power_down_pin,
    input  wire        spi_sck,
    input  wire        spi_mosi,
    input  wire        spi_ss_n,
    input  wire        tx_active,
    output reg         spi_miso_q,
    output reg         wake_irq_q,
    output reg         amp_control_pin_q,
    output reg         amp_output_enable_q,
    output reg         agc_reg_ctl_q,
    output reg         mid_enable_q,
    output reg         use_counters_q,
    output reg  [7:0]  syn_a_q,
    output reg  [7:0]  syn_n_q,
    output reg  [11:0] synth_mhz_q
);
    wire [4:0] pins_s;
    wire       pd_s   = pins_s[0];
    wire       sck_s  = pins_s[1];
    wire       mosi_s = pins_s[2];
    wire       ss_n_s = pins_s[3];
    wire       tx_s   = pins_s[4];
    pin_sync #(.W(5)) u_sync
    (
        .ref_clk (ref_clk),
        .srst    (srst),
        .pin_in  ({tx_active, spi_ss_n, spi_mosi, spi_sck, power_down_pin}),
        .pin_out (pins_s)
    );

    wire       miso;
    wire       rd_stb;
    wire       wr_stb;
    wire [5:0] addr;
    wire [7:0] wdata;
    reg  [7:0] rdata;
    spi_slave u_spi
    (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .sck       (sck_s),
        .mosi      (mosi_s),
        .ss_n      (ss_n_s),
        .rd_data   (rdata),
        .miso_q    (miso),
        .rd_stb_q  (rd_stb),
        .wr_stb_q  (wr_stb),
        .addr_q    (addr),
        .wr_data_q (wdata)
    );

    reg  [7:0] wake_en_q;
    reg        wake_pend_q;
    reg  [7:0] analog_q;
    reg  [7:0] channel_q;
    reg  [7:0] agc_q;
    reg  [7:0] rssi_ctl_q;
    reg        pd_q;
    reg        pd_seen_q;
    reg  [3:0] ready_cnt_q;
    reg  [7:0] syn_a_r;
    reg  [7:0] syn_n_r;

    localparam [7:0] WAKE_STAT_RST = `RST_WAKE_STAT;

    wire soft_rst = wr_stb && addr == `ADDR_ANALOG_CTL
                    && wdata[`BIT_SOFT_RST];
    wire regs_rst = srst | soft_rst;
    wire wr_en    = wr_stb & ~soft_rst;

    // Wake event after power-down release and ready delay
    wire wake_evt = pd_seen_q && ready_cnt_q == `READY_CYCLES;
    wire stat_rd  = rd_stb && addr == `ADDR_WAKE_STAT;

    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            pd_q        <= 1'b0;
            pd_seen_q   <= 1'b0;
            ready_cnt_q <= 4'h0;
        end
        else
        begin
            pd_q <= pd_s;
            if (pd_s)
            begin
                pd_seen_q   <= 1'b0;
                ready_cnt_q <= 4'h0;
            end
            else if (pd_q)
                pd_seen_q <= 1'b1;
            else if (pd_seen_q)
            begin
                if (ready_cnt_q == `READY_CYCLES)
                    pd_seen_q <= 1'b0;
                else
                    ready_cnt_q <= ready_cnt_q + 4'h1;
            end
            else
                ready_cnt_q <= 4'h0;
        end
    end

    always @(posedge ref_clk)
    begin
        if (regs_rst)
        begin
            wake_en_q   <= `RST_WAKE_EN;
            wake_pend_q <= WAKE_STAT_RST[`BIT_WAKE];
            analog_q    <= `RST_ANALOG_CTL;
            channel_q   <= `RST_CHANNEL;
            syn_a_r     <= `RST_SYN_A;
            syn_n_r     <= `RST_SYN_N;
            agc_q       <= `RST_AGC;
            rssi_ctl_q  <= `RST_AGC;
        end
        else
        begin
            // Set wins over read clear
            if (wake_evt)
                wake_pend_q <= 1'b1;
            else if (stat_rd)
                wake_pend_q <= 1'b0;
            if (wr_en)
            begin
                case (addr)
                    `ADDR_WAKE_EN:
                        wake_en_q <= wdata & `MASK_WAKE_EN;
                    `ADDR_ANALOG_CTL:
                        analog_q <= wdata & `MASK_ANALOG_CTL;
                    `ADDR_CHANNEL:
                        channel_q <= wdata;
                    `ADDR_SYN_A:
                        syn_a_r <= wdata;
                    `ADDR_SYN_N:
                        syn_n_r <= wdata;
                    `ADDR_AGC_CTL:
                        if (analog_q[`BIT_AGC_EN])
                            agc_q <= wdata;
                    `ADDR_RSSI_CTL:
                        if (analog_q[`BIT_AGC_EN])
                            rssi_ctl_q <= wdata;
                    default:
                        wake_en_q <= wake_en_q;
                endcase
            end
        end
    end

    // Identifier bytes, valid only while the enable bit is set
    localparam [31:0] MID_WORD = `MID_VALUE; // Arbitrary value
    wire [1:0] mid_idx = addr[1:0];
    wire [7:0] mid_byte = MID_WORD[8*mid_idx +: 8];

    always @*
    begin
        rdata = 8'h00;
        case (addr)
            `ADDR_WAKE_EN:    rdata = wake_en_q;
            `ADDR_WAKE_STAT:  rdata = {7'h00, wake_pend_q};
            `ADDR_ANALOG_CTL: rdata = analog_q;
            `ADDR_CHANNEL:    rdata = channel_q;
            `ADDR_SYN_A:      rdata = syn_a_r;
            `ADDR_SYN_N:      rdata = syn_n_r;
            `ADDR_AGC_CTL:    rdata = agc_q;
            `ADDR_RSSI_CTL:   rdata = rssi_ctl_q;
            default:
                if (addr >= `ADDR_MID_0 && analog_q[`BIT_MID_EN])
                    rdata = mid_byte;
                else
                    rdata = 8'h00;
        endcase
    end

    wire       amp_active = tx_s ^ analog_q[`BIT_AMP_INV];
    wire       an_sel     = channel_q[`BIT_AN_SEL];
    wire [11:0] freq_d    = `FREQ_BASE_MHZ + {5'h00, channel_q[6:0]};

    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            spi_miso_q          <= 1'b0;
            wake_irq_q          <= 1'b0;
            amp_control_pin_q   <= 1'b0;
            amp_output_enable_q <= 1'b0;
            agc_reg_ctl_q       <= 1'b0;
            mid_enable_q        <= 1'b0;
            use_counters_q      <= 1'b0;
            syn_a_q             <= 8'h00;
            syn_n_q             <= 8'h00;
            synth_mhz_q         <= 12'h000;
        end
        else
        begin
            spi_miso_q <= miso;
            wake_irq_q <= wake_en_q[`BIT_WAKE] & wake_pend_q;
            amp_output_enable_q <= analog_q[`BIT_AMP_OE];
            amp_control_pin_q   <= analog_q[`BIT_AMP_OE]
                                   & amp_active;
            agc_reg_ctl_q  <= analog_q[`BIT_AGC_EN];
            mid_enable_q   <= analog_q[`BIT_MID_EN];
            use_counters_q <= an_sel;
            syn_a_q        <= syn_a_r;
            syn_n_q        <= syn_n_r;
            if (an_sel)
                synth_mhz_q <= 12'h000;
            else
                synth_mhz_q <= freq_d;
        end
    end
endmodule // radio_wake_analog_channel_regs

//--- radio_regs_properties.sv
// Port checker for the wake, analog and channel register bank.
// Assumes a bind to the bank top; one ref_clk domain.
`timescale 1ns/1ps
module radio_regs_properties
(
    input wire        ref_clk,
    input wire        srst,
    input wire        spi_ss_n,
    input wire        tx_active,
    input wire        wake_irq_q,
    input wire        amp_control_pin_q,
    input wire        amp_output_enable_q,
    input wire        agc_reg_ctl_q,
    input wire        mid_enable_q,
    input wire        use_counters_q,
    input wire [11:0] synth_mhz_q
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    a_reset_quiet: assert property ($fell(srst) |-> !{wake_irq_q,
        amp_output_enable_q, amp_control_pin_q, synth_mhz_q})
        else $error("outputs not idle after reset");
    a_amp_off_low: assert property (!amp_output_enable_q |->
        !amp_control_pin_q) else $error("amp pin driven while off");
    a_amp_follow: assert property ($changed(tx_active) &&
        amp_output_enable_q |-> ##[1:5] $changed(amp_control_pin_q))
        else $error("amp pin missed tx change");
    a_amp_steady: assert property (($stable(tx_active) &&
        spi_ss_n)[*6] |-> $stable(amp_control_pin_q))
        else $error("amp pin moved without cause");
    a_counters_zero: assert property (use_counters_q &&
        $past(use_counters_q) |-> synth_mhz_q == 12'd0)
        else $error("channel used in counter mode");
    a_synth_range: assert property (!use_counters_q &&
        !$past(use_counters_q) && !$past(srst) && !$past(srst, 2)
        |-> synth_mhz_q >= 12'd2401 && synth_mhz_q <= 12'd2528)
        else $error("synth frequency out of range");
    a_irq_frame: assert property ($fell(wake_irq_q) &&
        !$past(srst) |-> !$past(spi_ss_n, 4))
        else $error("irq cleared outside access");
    a_cfg_frame: assert property ($changed({mid_enable_q,
        agc_reg_ctl_q, use_counters_q}) && !$past(srst)
        |-> !$past(spi_ss_n, 4)) else $error("config moved idle");
endmodule // radio_regs_properties

//--- spi_host_model.sv
// Host SPI master, mode 0, sck period 80 ns, MSB first.
// Assumes ref_clk at 125 MHz; xfer is called by the bench.
`timescale 1ns/1ps
module spi_host_model
(
    input  wire ref_clk,
    input  wire miso,
    output reg  sck,
    output reg  mosi,
    output reg  ss_n
);
    initial
    begin
        sck = 1'b0;
        mosi = 1'b1;
        ss_n = 1'b1;
    end
    task xfer(input [7:0] cmd, input [7:0] wd, output [7:0] rd);
        integer k;
        begin
            ss_n <= 1'b0;
            for (k = 15; k >= 0; k = k - 1)
            begin
                mosi <= k > 7 ? cmd[k - 8] : wd[k];
                repeat (5) @(posedge ref_clk);
                rd = {rd[6:0], miso};
                sck <= 1'b1;
                repeat (5) @(posedge ref_clk);
                sck <= 1'b0;
            end
            repeat (5) @(posedge ref_clk);
            ss_n <= 1'b1;
            mosi <= ~wd[0];
            repeat (6) @(posedge ref_clk);
        end
    endtask
endmodule // spi_host_model

//--- radio_wake_analog_channel_regs_tb.sv
// Bench for the wake, analog and channel register bank.
// Assumes the host model and the checker compiled first.
`timescale 1ns/1ps
`include "radio_regs_map.vh"
module radio_wake_analog_channel_regs_tb;
    reg         ref_clk = 1'b0;
    reg         srst = 1'b1;
    reg         pd = 1'b1;
    reg         tx = 1'b0;
    wire        sck, mosi, ss_n, miso, irq, oe, pin, agc, mid, cnt;
    wire [7:0]  sa, sn;
    wire [11:0] mhz;
    reg  [7:0]  r;
    integer     bad_count = 0;
    integer     tests_run = 0;
    integer     seed = 65;
    integer     i, k, v;
    integer     m [0:63];
    always #4 ref_clk = ~ref_clk;
    radio_wake_analog_channel_regs uut
    (
        .ref_clk(ref_clk), .srst(srst), .power_down_pin(pd),
        .spi_sck(sck), .spi_mosi(mosi), .spi_ss_n(ss_n),
        .tx_active(tx), .spi_miso_q(miso), .wake_irq_q(irq),
        .amp_control_pin_q(pin), .amp_output_enable_q(oe),
        .agc_reg_ctl_q(agc), .mid_enable_q(mid),
        .use_counters_q(cnt), .syn_a_q(sa), .syn_n_q(sn),
        .synth_mhz_q(mhz)
    );
    spi_host_model host
    (
        .ref_clk(ref_clk), .miso(miso), .sck(sck), .mosi(mosi),
        .ss_n(ss_n)
    );
    task close_out;
    begin
        if (bad_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    task chk(input [31:0] g, input [31:0] e);
    begin
        tests_run = tests_run + 1;
        if (g !== e)
        begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    end
    endtask
    task dflt;
    begin
        for (k = 0; k < 64; k = k + 1)
            m[k] = 0;
        m[29] = 1;
    end
    endtask
    task wr(input [5:0] a, input [7:0] d);
    begin
        host.xfer({2'b10, a}, d, r);
        if (a == 6'h20 && d[0])
            dflt;
        else if (a != 6'h1d && (a < 6'h2e || a > 6'h2f || m[32][6]))
            m[a] = a == 6'h1c ? d & 1 : a == 6'h20 ? d & 8'h66 : d;
    end
    endtask
    task rd(input [5:0] a);
    begin
        host.xfer({2'b00, a}, 8'h00, r);
        v = a < 60 ? m[a] : m[32][5] ? `MID_VALUE >> (8 * (a - 60)) : 0;
        chk(r, v & 255);
        if (a == 6'h1d)
            m[29] = 0;
    end
    endtask
    initial
    begin
        dflt;
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        pd <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rd(6'h1c);
        rd(6'h1d);
        rd(6'h1d);
        wr(6'h1c, 8'h01);
        chk(irq, 0);
        wr(6'h1d, 8'hff);
        rd(6'h1d);
        pd <= 1'b1;
        repeat (4) @(posedge ref_clk);
        pd <= 1'b0;
        repeat (20) @(posedge ref_clk);
        m[29] = 1;
        chk(irq, 1);
        wr(6'h1c, 8'h00);
        chk(irq, 0);
        wr(6'h1c, 8'h01);
        rd(6'h1d);
        chk(irq, 0);
        wr(6'h20, 8'h04);
        for (i = 0; i < 4; i = i + 1)
        begin
            if (i == 2)
                wr(6'h20, 8'h06);
            v = $random(seed);
            tx <= v[0];
            repeat (6) @(posedge ref_clk);
            chk({oe, pin}, {1'b1, tx ^ m[32][1]});
        end
        rd(6'h20);
        wr(6'h20, 8'h02);
        chk(pin, 0);
        rd(6'h3c);
        wr(6'h20, 8'h22);
        for (i = 60; i < 64; i = i + 1)
            rd(i[5:0]);
        chk(mid, 1);
        wr(6'h20, 8'h02);
        wr(6'h2e, 8'h5a);
        rd(6'h2e);
        wr(6'h20, 8'h42);
        wr(6'h2e, 8'h3c);
        rd(6'h2e);
        chk(agc, 1);
        for (i = 0; i < 6; i = i + 1)
        begin
            v = i < 2 ? 1 + 78 * i : {$random(seed)} % 80;
            wr(6'h21, v[7:0]);
            chk(mhz, 2401 + v);
        end
        wr(6'h21, 8'h85);
        wr(6'h01, 8'ha3);
        wr(6'h02, 8'h4e);
        chk({cnt, mhz, sa, sn}, {1'b1, 12'h0, 16'ha34e});
        wr(6'h20, 8'h01);
        rd(6'h21);
        rd(6'h1d);
        chk({agc, cnt}, 0);
        rd(6'h3a);
        close_out;
    end
    initial
    begin
        repeat (30000) @(posedge ref_clk);
        bad_count = bad_count + 1;
        close_out;
    end
endmodule // radio_wake_analog_channel_regs_tb
bind radio_wake_analog_channel_regs radio_regs_properties chk_i
(
    .ref_clk(ref_clk), .srst(srst), .spi_ss_n(spi_ss_n),
    .tx_active(tx_active), .wake_irq_q(wake_irq_q),
    .amp_control_pin_q(amp_control_pin_q),
    .amp_output_enable_q(amp_output_enable_q),
    .agc_reg_ctl_q(agc_reg_ctl_q), .mid_enable_q(mid_enable_q),
    .use_counters_q(use_counters_q), .synth_mhz_q(synth_mhz_q)
);
